// >>> spi_fw_defines.svh
// register map, field positions and reset values of the spi frame engine
`ifndef SPI_FW_DEFINES_SVH
`define SPI_FW_DEFINES_SVH
`define SPI_FW_ADDR_CTRL 4'h0
`define SPI_FW_ADDR_TXDATA 4'h4
`define SPI_FW_ADDR_STATUS 4'h8
`define SPI_FW_ADDR_RXDATA 4'hc
`define SPI_FW_PAGE 4'h0
`define SPI_FW_CTRL_EN 0
`define SPI_FW_CTRL_SLAVE 1
`define SPI_FW_CTRL_POL 2
`define SPI_FW_CTRL_PHA 3
`define SPI_FW_CTRL_WS 7:4
`define SPI_FW_CTRL_DIV 15:8
`define SPI_FW_CTRL_RESET 16'h0370
`define SPI_FW_WS_MIN 4'h3
`define SPI_FW_ST_TXFULL 0
`define SPI_FW_ST_BUSY 1
`define SPI_FW_ST_RXVALID 2
`endif

// >>> spi_fw_pkg.sv
// types shared by the spi frame engine
`default_nettype none
package spi_fw_pkg;
   // engine sequencing states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LEAD,
      ST_RUN,
      ST_GAP,
      ST_SLAVE
   } eng_state_t;
endpackage : spi_fw_pkg
`default_nettype wire

// >>> spi_fw_sync.sv
// three-stage pin synchroniser with a two-stage agreement filter
`default_nettype none
module spi_fw_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_level
);
   logic [WIDTH-1:0] s1_q; // metastability catcher, read by s2 only
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] lvl_q; // filtered level
   logic [WIDTH-1:0] lvl_d;

   // a change is taken only once stage two and three agree
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
      end
   end

   // shift chain and filtered level
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         lvl_q <= '0;
      end else begin
         s1_q <= i_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign o_level = lvl_q;
endmodule : spi_fw_sync
`default_nettype wire

// >>> spi_fw_engine.sv
// four-wire spi frame engine with ahb-lite register slave
// Functional notes
// [R1] idle clock level follows polarity select
// [R2] phase select picks first or second capture edge
// [R3] idle: select high, data low, pad off
// [R4] clock pad enabled as master, off as slave
// [R5] master starts when enabled and data waiting
// [R6] transmit pad enabled at transfer start
// [R7] phase 0: data half later, clock after
// [R8] phase 0: capture leading, change trailing edge
// [R9] slave drives first bit when selected
// [R10] single word: select rises one period later
// [R11] phase 0 back-to-back: select pulses high
// [R12] phase 0 slave freezes data while selected
// [R13] phase 0 stream ends one period later
// [R14] phase 1: data and clock half later
// [R15] phase 1: capture trailing, change leading edge
// [R16] phase 1 back-to-back: select stays low
// [R17] words four to sixteen bits, msb first
// [R18] polarity 1 phase 0: clock low later
// [R19] slave uses same edge rules, drives selected
// [R20] polarity 1 inverts clock only
//
// The address map and register access over AHB-Lite are this design's own decisions.
`default_nettype none
`include "spi_fw_defines.svh"
module spi_fw_engine (
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   output logic O_SERIAL_CLOCK_OUT,
   output logic O_CLOCK_OUTPUT_ENABLE_N,
   input wire logic I_SERIAL_CLOCK_IN,
   output logic O_FRAME_SELECT_OUT,
   input wire logic I_FRAME_SELECT_IN,
   output logic O_TX_DATA_LINE,
   output logic O_TX_OUTPUT_ENABLE_N,
   input wire logic I_RX_DATA_LINE
);
   // bus and register state
   logic [3:0] addr_q, addr_d; // data phase address
   logic wr_q, wr_d; // data phase is a write
   logic [15:0] ctrl_q, ctrl_d;
   logic [15:0] tx_word_q, tx_word_d; // one-word transmit holding
   logic tx_valid_q, tx_valid_d;
   logic rx_valid_q, rx_valid_d;
   logic [31:0] hrdata_q, hrdata_d;
   // engine state
   spi_fw_pkg::eng_state_t st_q, st_d;
   logic [7:0] div_q, div_d; // half period divider
   logic [5:0] k_q, k_d; // half period index in a word
   logic sclk_q, sclk_d, fss_q, fss_d, oe_n_q, oe_n_d, txd_q, txd_d;
   logic [15:0] shift_q, shift_d, rxsh_q, rxsh_d, rxword_q, rxword_d;
   logic first_q, first_d; // skip first launch edge
   logic [3:0] capn_q, capn_d; // slave capture count
   logic sclk_prev_q, sclk_prev_d;
   // decoded config and pulses
   logic en, slv, pol, pha, half_tick, consume, done, take;
   logic [3:0] ws; // word size minus one
   logic [15:0] wmask; // received word width mask
   logic [5:0] two_n, done_k;
   logic [2:0] pins_f; // filtered pins: clock, select, data
   logic sclk_f, fss_f, rx_f, lead_e, trail_e, cap, launch;

   // outside pins cross through four flops each
   spi_fw_sync #(.WIDTH(3)) u_sync (
      .i_clk(I_CORE_CLK),
      .i_rst(I_RST),
      .i_async({I_SERIAL_CLOCK_IN, I_FRAME_SELECT_IN, I_RX_DATA_LINE}),
      .o_level(pins_f)
   );
   assign sclk_f = pins_f[2];
   assign fss_f = pins_f[1];
   assign rx_f = pins_f[0];

   // config decode; undersized words clamp to four bits
   assign en = ctrl_q[`SPI_FW_CTRL_EN];
   assign slv = ctrl_q[`SPI_FW_CTRL_SLAVE];
   assign pol = ctrl_q[`SPI_FW_CTRL_POL];
   assign pha = ctrl_q[`SPI_FW_CTRL_PHA];
   // [R17] word length limits
   assign ws = (ctrl_q[`SPI_FW_CTRL_WS] < `SPI_FW_WS_MIN) ?
               `SPI_FW_WS_MIN : ctrl_q[`SPI_FW_CTRL_WS];
   assign two_n = {1'b0, ws, 1'b0} + 6'h02;
   assign done_k = two_n + {5'h00, pha};
   // [R17] a word keeps only its own ws+1 received bits
   assign wmask = ~(16'hfffe << ws);
   assign half_tick = (div_q == ctrl_q[`SPI_FW_CTRL_DIV]);
   assign take = I_HSEL & I_HTRANS[1] & I_HREADY;
   // slave clock edges relative to the idle level
   assign lead_e = (sclk_f != sclk_prev_q) && (sclk_f != pol);
   assign trail_e = (sclk_f != sclk_prev_q) && (sclk_f == pol);

   // engine next state
   always_comb begin
      st_d = st_q;
      div_d = (st_q == spi_fw_pkg::ST_IDLE || half_tick) ?
              8'h00 : div_q + 8'h01;
      k_d = k_q;
      sclk_d = sclk_q;
      fss_d = fss_q;
      oe_n_d = oe_n_q;
      txd_d = txd_q;
      shift_d = shift_q;
      rxsh_d = rxsh_q;
      rxword_d = rxword_q;
      first_d = first_q;
      capn_d = capn_q;
      sclk_prev_d = sclk_f;
      consume = 1'b0;
      done = 1'b0;
      cap = 1'b0;
      launch = 1'b0;
      unique case (st_q)
         spi_fw_pkg::ST_IDLE: begin
            // [R1] clock rests at polarity level
            sclk_d = pol;
            // [R3] idle pin levels
            fss_d = 1'b1;
            oe_n_d = 1'b1;
            txd_d = 1'b0;
            // [R5] master start condition
            if (en && !slv && tx_valid_q) begin
               consume = 1'b1;
               shift_d = tx_word_q;
               fss_d = 1'b0;
               // [R6] pad on with select
               oe_n_d = 1'b0;
               st_d = spi_fw_pkg::ST_LEAD;
            end else if (en && slv && !fss_f) begin
               // empty holding sends zeros
               consume = tx_valid_q;
               shift_d = tx_valid_q ? tx_word_q : 16'h0000;
               // [R19] drive only while selected
               oe_n_d = 1'b0;
               txd_d = shift_d[ws];
               first_d = pha;
               capn_d = 4'h0;
               st_d = spi_fw_pkg::ST_SLAVE;
            end
         end
         spi_fw_pkg::ST_LEAD: begin
            if (half_tick) begin
               // [R7] msb half period after select
               txd_d = shift_q[ws];
               k_d = {5'h00, pha};
               // [R14] phase 1 clock starts with data
               if (pha) begin
                  sclk_d = ~sclk_q;
               end
               st_d = spi_fw_pkg::ST_RUN;
            end
         end
         spi_fw_pkg::ST_RUN: begin
            if (half_tick) begin
               k_d = k_q + 6'h01;
               if (k_q < two_n) begin
                  // [R20] polarity only sets the rest level
                  sclk_d = ~sclk_q;
                  // [R2] capture parity follows phase
                  cap = (k_q[0] == pha);
                  launch = !cap;
               end
               // [R8] [R15] [R18] sample then shift
               if (cap) begin
                  rxsh_d = {rxsh_q[14:0], rx_f};
               end
               if (launch) begin
                  shift_d = {shift_q[14:0], 1'b0};
                  txd_d = shift_q[ws - 4'h1];
               end
               if (k_q == done_k) begin
                  done = 1'b1;
                  rxword_d = rxsh_q & wmask;
                  // [R16] phase 1 keeps select low
                  if (pha && en && !slv && tx_valid_q) begin
                     consume = 1'b1;
                     shift_d = tx_word_q;
                     st_d = spi_fw_pkg::ST_LEAD;
                  end else begin
                     // [R10] [R11] [R13] select back high
                     fss_d = 1'b1;
                     oe_n_d = 1'b1;
                     txd_d = 1'b0;
                     st_d = spi_fw_pkg::ST_GAP;
                  end
               end
            end
         end
         spi_fw_pkg::ST_GAP: begin
            // select high for one half period
            if (half_tick) begin
               st_d = spi_fw_pkg::ST_IDLE;
            end
         end
         spi_fw_pkg::ST_SLAVE: begin
            // [R19] same edge rules on incoming clock
            cap = pha ? trail_e : lead_e;
            launch = pha ? lead_e : trail_e;
            if (fss_f || !en || !slv) begin
               oe_n_d = 1'b1;
               txd_d = 1'b0;
               st_d = spi_fw_pkg::ST_IDLE;
            end else if (cap) begin
               rxsh_d = {rxsh_q[14:0], rx_f};
               capn_d = capn_q + 4'h1;
               if (capn_q == ws) begin
                  done = 1'b1;
                  rxword_d = rxsh_d & wmask;
                  capn_d = 4'h0;
                  // phase 1 streams reload without deselect
                  if (pha) begin
                     consume = tx_valid_q;
                     shift_d = tx_valid_q ? tx_word_q : 16'h0000;
                     first_d = 1'b1;
                     txd_d = shift_d[ws];
                  end
               end
            end else if (launch) begin
               if (first_q) begin
                  first_d = 1'b0;
               end else begin
                  shift_d = {shift_q[14:0], 1'b0};
                  txd_d = shift_q[ws - 4'h1];
               end
            end
         end
      endcase
   end

   // engine registers
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         st_q <= spi_fw_pkg::ST_IDLE;
         div_q <= 8'h00;
         k_q <= 6'h00;
         sclk_q <= 1'b0;
         fss_q <= 1'b1;
         oe_n_q <= 1'b1;
         txd_q <= 1'b0;
         shift_q <= 16'h0000;
         rxsh_q <= 16'h0000;
         rxword_q <= 16'h0000;
         first_q <= 1'b0;
         capn_q <= 4'h0;
         sclk_prev_q <= 1'b0;
      end else begin
         st_q <= st_d;
         div_q <= div_d;
         k_q <= k_d;
         sclk_q <= sclk_d;
         fss_q <= fss_d;
         oe_n_q <= oe_n_d;
         txd_q <= txd_d;
         shift_q <= shift_d;
         rxsh_q <= rxsh_d;
         rxword_q <= rxword_d;
         first_q <= first_d;
         capn_q <= capn_d;
         sclk_prev_q <= sclk_prev_d;
      end
   end

   // bus slave next state; zero wait states
   always_comb begin
      addr_d = take ? I_HADDR[3:0] : addr_q;
      wr_d = take & I_HWRITE & (I_HADDR[7:4] == `SPI_FW_PAGE);
      ctrl_d = ctrl_q;
      tx_word_d = tx_word_q;
      tx_valid_d = tx_valid_q;
      rx_valid_d = rx_valid_q;
      hrdata_d = hrdata_q;
      // a taken word frees the holding register
      if (consume) begin
         tx_valid_d = 1'b0;
      end
      // write data phase; a new word overwrites
      if (wr_q && addr_q == `SPI_FW_ADDR_CTRL) begin
         ctrl_d = I_HWDATA[15:0];
      end
      if (wr_q && addr_q == `SPI_FW_ADDR_TXDATA) begin
         tx_word_d = I_HWDATA[15:0];
         tx_valid_d = 1'b1;
      end
      // read data registered at the address phase
      if (take && !I_HWRITE) begin
         hrdata_d = 32'h00000000;
         if (I_HADDR[7:4] == `SPI_FW_PAGE) begin
            unique case (I_HADDR[3:0])
               `SPI_FW_ADDR_CTRL: hrdata_d = {16'h0000, ctrl_q};
               `SPI_FW_ADDR_STATUS: begin
                  hrdata_d[`SPI_FW_ST_TXFULL] = tx_valid_q;
                  hrdata_d[`SPI_FW_ST_BUSY] =
                     (st_q != spi_fw_pkg::ST_IDLE);
                  hrdata_d[`SPI_FW_ST_RXVALID] = rx_valid_q;
               end
               `SPI_FW_ADDR_RXDATA: begin
                  hrdata_d = {16'h0000, rxword_q};
                  rx_valid_d = 1'b0;
               end
               default: hrdata_d = 32'h00000000;
            endcase
         end
      end
      // a finishing word wins over a read clear
      if (done) begin
         rx_valid_d = 1'b1;
      end
   end

   // bus slave registers
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         addr_q <= 4'h0;
         wr_q <= 1'b0;
         ctrl_q <= `SPI_FW_CTRL_RESET;
         tx_word_q <= 16'h0000;
         tx_valid_q <= 1'b0;
         rx_valid_q <= 1'b0;
         hrdata_q <= 32'h00000000;
      end else begin
         addr_q <= addr_d;
         wr_q <= wr_d;
         ctrl_q <= ctrl_d;
         tx_word_q <= tx_word_d;
         tx_valid_q <= tx_valid_d;
         rx_valid_q <= rx_valid_d;
         hrdata_q <= hrdata_d;
      end
   end

   assign O_HRDATA = hrdata_q;
   assign O_HREADYOUT = 1'b1;
   assign O_HRESP = 1'b0;
   assign O_SERIAL_CLOCK_OUT = sclk_q;
   // [R4] clock pad follows master or slave
   assign O_CLOCK_OUTPUT_ENABLE_N = slv;
   assign O_FRAME_SELECT_OUT = fss_q;
   assign O_TX_DATA_LINE = txd_q;
   assign O_TX_OUTPUT_ENABLE_N = oe_n_q;

   // checks
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RST);
   logic idle_st;
   assign idle_st = (st_q == spi_fw_pkg::ST_IDLE);
   AST_IDLE_CLK: assert property ($past(idle_st) && idle_st |-> // [R1]
      O_SERIAL_CLOCK_OUT == $past(pol)) else $error("idle clock level");
   AST_IDLE_PINS: assert property (idle_st |-> O_FRAME_SELECT_OUT && // [R3]
      !O_TX_DATA_LINE && O_TX_OUTPUT_ENABLE_N) else $error("idle pins");
   AST_CTL_PAD: assert property (st_q == spi_fw_pkg::ST_RUN |-> // [R4]
      !O_CLOCK_OUTPUT_ENABLE_N) else $error("clock pad enable");
   AST_START: assert property ($fell(O_FRAME_SELECT_OUT) |-> // [R5]
      $past(en && !slv && tx_valid_q)) else $error("bad start");
   AST_OE_START: assert property ($fell(O_FRAME_SELECT_OUT) |-> // [R6]
      !O_TX_OUTPUT_ENABLE_N) else $error("pad off at start");
   AST_PH0_LEAD: assert property (st_q == spi_fw_pkg::ST_LEAD && // [R7]
      half_tick && !pha |=> O_SERIAL_CLOCK_OUT == pol
      && st_q == spi_fw_pkg::ST_RUN) else $error("phase 0 lead");
   AST_PH1_LEAD: assert property (st_q == spi_fw_pkg::ST_LEAD && // [R14]
      half_tick && pha |=> O_SERIAL_CLOCK_OUT != pol)
      else $error("phase 1 lead");
   AST_CAP_EDGE: assert property (cap && st_q == spi_fw_pkg::ST_RUN |=> // [R2]
      (O_SERIAL_CLOCK_OUT != pol) == !pha) else $error("capture edge");
   AST_END_TIME: assert property (done && !slv |-> // [R10]
      O_SERIAL_CLOCK_OUT == pol) else $error("end timing");
   AST_PH0_GAP: assert property (done && !slv && !pha |=> // [R11]
      O_FRAME_SELECT_OUT [*2]) else $error("no select pulse");
   AST_PH1_HOLD: assert property (done && !slv && pha && tx_valid_q // [R16]
      && en |=> !O_FRAME_SELECT_OUT) else $error("select rose");
   AST_SLV_OE: assert property (slv && fss_f && !idle_st |=> // [R19]
      O_TX_OUTPUT_ENABLE_N) else $error("slave drives deselected");
   COV_PH0: cover property (done && !slv && !pha);
   COV_PH1_B2B: cover property (done && !slv && pha && tx_valid_q);
   COV_SLAVE: cover property (done && slv);
endmodule : spi_fw_engine
`default_nettype wire

// >>> spi_far_slave.sv
// behavioural far-side spi slave for the frame engine bench
`default_nettype none
module spi_far_slave (
   input wire logic i_sclk,
   input wire logic i_sel_n,
   input wire logic i_mosi,
   input wire logic i_pol,
   input wire logic i_pha,
   input wire logic [15:0] i_word,
   input wire logic [4:0] i_nbits,
   output logic o_miso,
   output logic [15:0] o_rx
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt; // bits captured in this word
   initial begin
      o_miso = 1'b0;
      o_rx = '0;
      cnt = 0;
   end
   always @(negedge i_sel_n) begin
      cnt = 0;
      if (!i_pha) o_miso = i_word[i_nbits-1];
   end
   // released line inverts, so stale data never matches
   always @(posedge i_sel_n) o_miso = ~o_miso;
   always @(i_sclk) begin
      if (!i_sel_n) begin
         // capture edge: leading for phase 0, trailing for phase 1
         if ((i_sclk !== i_pol) == !i_pha) begin
            o_rx = {o_rx[14:0], i_mosi};
            cnt = cnt + 1;
            if (i_pha && cnt == i_nbits) cnt = 0;
         end else if (i_pha || cnt < i_nbits) begin
            o_miso = i_word[i_nbits-1-cnt];
         end
      end
   end
endmodule : spi_far_slave
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the four-wire spi frame engine
`default_nettype none
`include "spi_fw_defines.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
   n_errors++; $display("Error %s exp %h got %h", nm, e, g); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, hsel, hwrite, sclk_in, fss_in, rx_in, slv, pol, pha;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic hreadyout, hresp, sclk, cke_n, fss, txd, txe_n, miso, oe0;
   logic [15:0] srx;
   logic [7:0] got;
   logic sclk_p, fss_p, txd_p;
   wire logic hready; // single slave: its ready is the bus ready
   wire logic rxd; // far slave in master mode, bench in slave mode
   int n_errors = 0;
   int n_tests = 0;
   int cyc, t_edge, t_last, t_txd, t_rise, n_tog, n_rise;
   assign hready = hreadyout;
   assign rxd = slv ? rx_in : miso;
   spi_fw_engine dut (.I_CORE_CLK(clk), .I_RST(rst), .I_HSEL(hsel),
      .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
      .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
      .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout), .O_HRESP(hresp),
      .O_SERIAL_CLOCK_OUT(sclk), .O_CLOCK_OUTPUT_ENABLE_N(cke_n),
      .I_SERIAL_CLOCK_IN(sclk_in), .O_FRAME_SELECT_OUT(fss),
      .I_FRAME_SELECT_IN(fss_in), .O_TX_DATA_LINE(txd),
      .O_TX_OUTPUT_ENABLE_N(txe_n), .I_RX_DATA_LINE(rxd));
   spi_far_slave far (.i_sclk(sclk), .i_sel_n(fss), .i_mosi(txd),
      .i_pol(pol), .i_pha(pha), .i_word(16'h003c), .i_nbits(5'd8),
      .o_miso(miso), .o_rx(srx));
   // 25 mhz core clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // pin timing per frame, counted in core cycles from select fall
   always @(posedge clk) begin
      if (fss_p === 1'b1 && fss === 1'b0) begin
         cyc = 0;
         n_tog = 0;
         t_edge = -1;
         t_txd = -1;
         oe0 = txe_n;
      end else cyc++;
      if (sclk !== sclk_p) begin
         n_tog++;
         t_last = cyc;
         if (t_edge < 0) t_edge = cyc;
      end
      if (txd === 1'b1 && txd_p === 1'b0 && t_txd < 0) t_txd = cyc;
      if (fss === 1'b1 && fss_p === 1'b0) begin
         n_rise++;
         t_rise = cyc;
      end
      sclk_p = sclk;
      fss_p = fss;
      txd_p = txd;
   end
   // verdict and end of run
   task automatic conclude();
      if (n_errors == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   // one ahb-lite single transfer; waits on hready, bounded
   task automatic bus(input logic wr, input logic [31:0] a,
         input logic [31:0] wd, output logic [31:0] q);
      int k;
      k = 0;
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 99);
      htrans <= 2'b00;
      hwdata <= wd;
      do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 99);
      q = hrdata;
      if (k >= 99) begin n_errors++; conclude(); end
   endtask : bus
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   // poll status until the masked flags clear, bounded
   task automatic wait_st(input logic [31:0] m);
      int k;
      k = 0;
      do begin bus(1'b0, `SPI_FW_ADDR_STATUS, 0, rd); k++; end
      while ((rd & m) !== 32'h0 && k < 500);
      if (k >= 500) begin n_errors++; conclude(); end
   endtask : wait_st
   initial begin
      {rst, hsize} = 4'b1010;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      {sclk_in, fss_in, rx_in, slv, pol, pha} = 6'b010000;
      {n_rise, t_rise, t_last} = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK("rst sclk", 1'b0, sclk)
      `CHK("rst fss", 1'b1, fss)
      `CHK("rst txd", 1'b0, txd)
      `CHK("rst txoe", 1'b1, txe_n)
      `CHK("rst ckoe", 1'b0, cke_n)
      bus(1'b0, `SPI_FW_ADDR_CTRL, 0, rd);
      `CHK("ctrl", 32'h0370, rd)
      bus(1'b0, 32'h10, 0, rd);
      `CHK("unmapped", 32'h0, rd)
      // four clock modes, 8-bit words, half period of 5 cycles
      for (int m = 0; m < 4; m++) begin
         pol = m[1];
         pha = m[0];
         wr(`SPI_FW_ADDR_CTRL, {28'h0000047, pha, pol, 2'b00});
         wr(`SPI_FW_ADDR_TXDATA, 32'h00a5);
         repeat (10) @(posedge clk);
         `CHK("idle clk", pol, sclk)
         `CHK("no start", 1'b1, fss)
         wr(`SPI_FW_ADDR_CTRL, {28'h0000047, pha, pol, 2'b01});
         wait_st(32'h3);
         `CHK("start oe", 1'b0, oe0)
         `CHK("first edge", pha ? 5 : 10, t_edge)
         `CHK("txd lead", 5, t_txd)
         `CHK("toggles", 16, n_tog)
         `CHK("end fss", pha ? 10 : 5, t_rise - t_last)
         `CHK("far rx", 16'h00a5, srx & 16'h00ff)
         bus(1'b0, `SPI_FW_ADDR_RXDATA, 0, rd);
         `CHK("rx word", 32'h003c, rd)
         `CHK("idle oe", 1'b1, txe_n)
      end
      // two words back to back in each phase
      for (int p = 0; p < 2; p++) begin
         {pol, pha} = {1'b0, p[0]};
         wr(`SPI_FW_ADDR_CTRL, {28'h0000047, pha, 3'b001});
         n_rise = 0;
         wr(`SPI_FW_ADDR_TXDATA, 32'h00a5);
         wait_st(32'h1);
         wr(`SPI_FW_ADDR_TXDATA, 32'h00a5);
         wait_st(32'h3);
         `CHK("fss rises", pha ? 1 : 2, n_rise)
         `CHK("far rx2", 16'ha5a5, srx)
      end
      // slave mode, bench is the far master, 320 ns link clock
      slv = 1'b1;
      wr(`SPI_FW_ADDR_CTRL, 32'h0473);
      wr(`SPI_FW_ADDR_TXDATA, 32'h0096);
      `CHK("slave ckoe", 1'b1, cke_n)
      `CHK("slave idle", 1'b1, txe_n)
      fss_in <= 1'b0;
      rx_in <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK("slave oe", 1'b0, txe_n)
      // sampled late: the slave answers an edge five core cycles on
      for (int i = 7; i >= 0; i--) begin
         sclk_in <= 1'b1;
         repeat (4) @(posedge clk);
         got[i] = txd;
         sclk_in <= 1'b0;
         if (i > 0) rx_in <= ~i[0];
         repeat (4) @(posedge clk);
      end
      fss_in <= 1'b1;
      repeat (10) @(posedge clk);
      `CHK("slave tx", 8'h96, got)
      `CHK("slave off", 1'b1, txe_n)
      bus(1'b0, `SPI_FW_ADDR_RXDATA, 0, rd);
      `CHK("slave rx", 32'h00aa, rd)
      conclude();
   end
endmodule : tb_top
`default_nettype wire
